// *** design/wdk_params.svh ***
`ifndef WDK_PARAMS_SVH
`define WDK_PARAMS_SVH
// How it works
// - An overflow of the counter while the watchdog is active raises the system reset request.
// - Every system reset leaves the watchdog enabled, counting, at the longest interval.
// - After reset the interval field reads 111b and the whole control register reads 0x17.
// - Writing 0xA5 enables the watchdog and reloads its counter.
// - Only 0xDE followed by 0xAD within four system clocks stops the watchdog.
// - Writing 0xFF sets a lock, cleared only by reset, that defeats every later disable.
// - The lock write neither enables nor reloads the watchdog.
// - A write with bit 7 clear stores its low three bits as the interval selector.
// - The timeout is the slow clock period times four to the power selector plus three.
// - A read returns the interval selector in bits 2 to 0.
// - A read returns bit 4 high while active and low while disabled.
// - The counter is sixteen bits on the slow clock, which is held on while active.
// - The watchdog reset leaves the external reset pin alone.
`define WDK_CTRL_ADDR 8'h97
`define WDK_CTRL_RESET 8'h17
`define WDK_KEY_RESTART 8'hA5
`define WDK_KEY_DIS1 8'hDE
`define WDK_KEY_DIS2 8'hAD
`define WDK_KEY_LOCK 8'hFF
`define WDK_SEL_LSB 0
`define WDK_SEL_MSB 2
`define WDK_ACTIVE_BIT 4
`define WDK_CMD_BIT 7
`define WDK_SEL_RESET 3'h7
`define WDK_DIS_WINDOW_CYC 3'h4
`define WDK_PRESCALE_BITS 6
`endif

// *** design/wdk_pkg.sv ***
package wdk_pkg;
  typedef enum logic [2:0] {
    WDK_WR_NONE,
    WDK_WR_RESTART,
    WDK_WR_DIS1,
    WDK_WR_DIS2,
    WDK_WR_LOCK,
    WDK_WR_INTERVAL
  } wdk_write_t;
endpackage : wdk_pkg

// *** design/wdk_top.sv ***
`timescale 1ns/1ps
`include "wdk_params.svh"
module wdk_top
  import wdk_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // control register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // slow oscillator
  input wire logic slow_osc_clk,
  output logic slow_osc_force_on,
  // system reset request
  output logic wdt_reset_req
);
  localparam int PW = `WDK_PRESCALE_BITS;

  logic sync1, sync2, sync3, slow_level;
  logic next_slow_level;
  logic [2:0] sel, next_sel;
  logic active, next_active;
  logic locked, next_locked;
  logic [2:0] dis_win, next_dis_win;
  logic [PW-1:0] pre, next_pre;
  logic [COUNT_W-1:0] cnt, next_cnt;
  logic [COUNT_W-1:0] term;
  logic [7:0] next_rdata;
  logic next_reset_req;
  logic tick;
  wdk_write_t wr_kind;

  // write decode
  always_comb begin
    wr_kind = WDK_WR_NONE;
    if (sfr_wr && sfr_addr == `WDK_CTRL_ADDR) begin
      if (!sfr_wdata[`WDK_CMD_BIT]) begin
        wr_kind = WDK_WR_INTERVAL;
      end else begin
        case (sfr_wdata)
          `WDK_KEY_RESTART: wr_kind = WDK_WR_RESTART;
          `WDK_KEY_DIS1: wr_kind = WDK_WR_DIS1;
          `WDK_KEY_DIS2: wr_kind = WDK_WR_DIS2;
          `WDK_KEY_LOCK: wr_kind = WDK_WR_LOCK;
          default: wr_kind = WDK_WR_NONE;
        endcase
      end
    end
  end

  // slow clock edge: counts once second and third stages agree
  always_comb begin
    next_slow_level = slow_level;
    tick = 1'b0;
    if (sync2 == sync3 && sync3 != slow_level) begin
      next_slow_level = sync3;
      tick = sync3;
    end
  end

  // terminal count: 64 * 4^sel slow periods = 4^(sel+3)
  always_comb begin
    term = '0;
    term[{sel, 1'b0}] = 1'b1;
  end

  always_comb begin
    next_sel = sel;
    next_active = active;
    next_locked = locked;
    next_dis_win = (dis_win != 3'h0) ? dis_win - 3'h1 : 3'h0;
    next_pre = pre;
    next_cnt = cnt;
    next_reset_req = wdt_reset_req;
    if (active && tick) begin
      next_pre = pre + 1'b1;
      if (pre == {PW{1'b1}}) begin
        if (cnt == term - 1'b1) begin
          next_reset_req = 1'b1;
          next_cnt = '0;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
    end
    case (wr_kind)
      WDK_WR_RESTART: begin
        next_active = 1'b1;
        next_cnt = '0;
        next_pre = '0;
      end
      WDK_WR_DIS1: next_dis_win = `WDK_DIS_WINDOW_CYC;
      WDK_WR_DIS2: begin
        if (dis_win != 3'h0 && !locked) begin
          next_active = 1'b0;
        end
        next_dis_win = 3'h0;
      end
      WDK_WR_LOCK: next_locked = 1'b1;
      WDK_WR_INTERVAL: begin
        next_sel = sfr_wdata[`WDK_SEL_MSB:`WDK_SEL_LSB];
      end
      default: begin
      end
    endcase
  end

  // read data
  always_comb begin
    next_rdata = sfr_rdata;
    if (sfr_rd && sfr_addr == `WDK_CTRL_ADDR) begin
      next_rdata = 8'h00;
      next_rdata[`WDK_SEL_MSB:`WDK_SEL_LSB] = sel;
      next_rdata[`WDK_ACTIVE_BIT] = active;
    end else if (sfr_rd) begin
      next_rdata = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      slow_level <= 1'b0;
      sel <= `WDK_SEL_RESET;
      active <= 1'b1;
      locked <= 1'b0;
      dis_win <= 3'h0;
      pre <= '0;
      cnt <= '0;
      wdt_reset_req <= 1'b0;
      sfr_rdata <= `WDK_CTRL_RESET;
      slow_osc_force_on <= 1'b1;
    end else if (ce) begin
      sync1 <= slow_osc_clk;
      sync2 <= sync1;
      sync3 <= sync2;
      slow_level <= next_slow_level;
      sel <= next_sel;
      active <= next_active;
      locked <= next_locked;
      dis_win <= next_dis_win;
      pre <= next_pre;
      cnt <= next_cnt;
      wdt_reset_req <= next_reset_req;
      sfr_rdata <= next_rdata;
      slow_osc_force_on <= next_active;
    end
  end
endmodule : wdk_top

// *** tb/wdk_props.sv ***
`timescale 1ns/1ps
module wdk_props #(parameter int COUNT_W = 16) (
  input wire logic clk_sys, rst, ce, sfr_wr, sfr_rd, slow_osc_clk,
  input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
  input wire logic slow_osc_force_on, wdt_reset_req
);
  wire w = ce && sfr_wr && sfr_addr == 8'h97;
  wire ad = w && sfr_wdata == 8'hAD;
  wire rd = ce && sfr_rd && sfr_addr == 8'h97;
  wire on = slow_osc_force_on;
  wire rq = wdt_reset_req;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  rst_val_a:
    assert property ($fell(rst) |-> sfr_rdata == 8'h17 && on) else $error("rst");
  restart_a:
    assert property (w && sfr_wdata == 8'hA5 |=> on) else $error("a5");
  // bit 1 set: first disable key, lock key, unknown keys
  key_ign_a:
    assert property (w && sfr_wdata[7] && sfr_wdata[1] |=> $stable(on)) else $error("key");
  stop_a:
    assert property ($fell(on) |-> $past(ad)) else $error("stop");
  req_hold_a:
    assert property (rq |=> rq) else $error("hold");
  req_cause_a:
    assert property ($rose(rq) |-> $past(on)) else $error("req");
  rd_act_a:
    assert property (rd |=> sfr_rdata[4] == $past(on)) else $error("act");
  sel_a:
    assert property (w && !sfr_wdata[7] ##1 !w ##1 rd |=>
      sfr_rdata[2:0] == $past(sfr_wdata[2:0], 3)) else $error("sel");
  cover property ($rose(rq));
  cover property ($fell(on));
  cover property (ad && on);
endmodule : wdk_props
bind wdk_top wdk_props #(.COUNT_W(COUNT_W)) chk_u (.*);

// *** tb/tb_wdk_top.sv ***
`timescale 1ns/1ps
module tb_wdk_top;
  logic clk_sys = 0, rst = 1, ce = 1, sfr_wr = 0, sfr_rd = 0, pend = 0;
  logic slow_osc_clk = 0, slow_osc_force_on, wdt_reset_req;
  logic [7:0] sfr_addr = 8'h97, sfr_wdata = 8'h00, sfr_rdata, s, q[$];
  int error_cnt = 0, cmp_count = 0, n;
  wdk_top dut_u (.*);
  initial forever #5 clk_sys = ~clk_sys;
  initial forever #40 slow_osc_clk = ~slow_osc_clk;
  task chk(input logic [7:0] g, e);
    cmp_count++;
    if (g !== e) $display("BAD %0t %h %h", $time, g, e);
    error_cnt += int'(g !== e);
  endtask : chk
  task conclude;
    $display("cmp %0d err %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // write v, or read and expect v
  task op(input logic w, input logic [7:0] v);
    @(posedge clk_sys) #1 {sfr_wr, sfr_rd, sfr_wdata} = {w, !w, v};
    if (!w) q.push_back(v);
    @(posedge clk_sys) #1 {sfr_wr, sfr_rd} = 2'b00;
  endtask : op
  always @(negedge clk_sys) begin
    if (pend) chk(sfr_rdata, q.pop_front());
    pend = sfr_rd;
  end
  initial begin
    n = $urandom(32'h753C691B);
    s = 8'($urandom % 8);
    repeat (20) @(posedge clk_sys);
    #1 rst = 0;
    op(0, 8'h17);
    op(1, s);
    op(0, 8'h10 | s);
    op(1, 8'hC3);
    sfr_addr = 8'h96;
    op(0, 8'h00);
    sfr_addr = 8'h97;
    op(0, 8'h10 | s);
    $display("test 1 done");
    op(1, 8'hDE);
    repeat (4) @(posedge clk_sys);
    op(1, 8'hAD);
    op(0, 8'h10 | s);
    op(1, 8'hDE);
    op(1, 8'hAD);
    op(1, 8'hFF);
    op(0, s);
    repeat (600) @(posedge clk_sys);
    #1 chk(8'(wdt_reset_req), 8'h00);
    op(1, 8'hA5);
    op(1, 8'hDE);
    op(1, 8'hAD);
    op(0, 8'h10 | s);
    $display("test 2 done");
    op(1, 8'h00);
    repeat (8) begin
      repeat (400) @(posedge clk_sys);
      op(1, 8'hA5);
    end
    chk(8'(wdt_reset_req), 8'h00);
    for (n = 0; n < 600 && !wdt_reset_req; n++) @(posedge clk_sys) #1;
    chk(8'(n > 495 && n < 535), 8'h01);
    #1 rst = 1;
    repeat (3) @(posedge clk_sys);
    #1 rst = 0;
    op(0, 8'h17);
    op(1, 8'hDE);
    op(1, 8'hAD);
    ce = 0;
    op(1, 8'h03);
    ce = 1;
    op(0, 8'h07);
    $display("test 3 done");
    #6 conclude();
  end
endmodule : tb_wdk_top
